// File: logic/async_serial_transmitter.sv
// async serial transmitter: AXI4-Lite registers, holding register, baud divider and frame shifter
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns

// ****************************************************************
// behaviour
// ****************************************************************
module async_serial_transmitter #(
  parameter int DIV_WIDTH = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  output logic             serial_out_internal
);
  import serial_tx_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]           tx_ctrl;    // transmit_status_control, writable bits
    logic [7:0]           rx_ctrl;    // receive_status_control
    logic [7:0]           baud_ctrl;  // baud_control
    logic [DIV_WIDTH-1:0] divisor;
    logic [7:0]           holding;    // transmit_holding_register
    logic                 held_nine;  // ninth bit captured with the character
    logic                 pending;    // character waiting in holding register
    logic                 aw_got;
    logic [7:0]           aw_addr;
    logic                 w_got;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 out_q;      // registered line after polarity
    logic                 oe_q;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic       active;
  logic       tick;
  logic       shift_empty;
  logic       stop_begun;
  logic       raw_line;
  logic       load;
  logic       wr_fire;
  logic       holding_empty;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // merge write data into an 8-bit register under the low byte strobe
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge8 = strb[0] ? data[7:0] : old;
  endfunction

  // word-align an address and check it is mapped
  function automatic logic mapped(input logic [7:0] addr);
    case ({addr[7:2], 2'b00})
      ADDR_TX_STATUS_CONTROL, ADDR_RX_STATUS_CONTROL, ADDR_BAUD_CONTROL,
      ADDR_BAUD_DIVISOR, ADDR_HOLDING, ADDR_FLAGS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // enable decode
  // ****************************************************************
  // transmitter runs only in async mode with both enables set
  assign active = s_q.tx_ctrl[BIT_TX_ENABLE] & ~s_q.tx_ctrl[BIT_SYNC_MODE]
                & s_q.rx_ctrl[BIT_PORT_ENABLE];
  // flag tracks the holding register while active; it reads clear whenever the path is disabled
  assign holding_empty = active & ~s_q.pending;
  // holding register hands over when shifter idle or stop bit begins
  assign load = active & s_q.pending & (shift_empty | stop_begun);

  // ****************************************************************
  // bit timing and shifter
  // ****************************************************************
  baud_divider #(
    .WIDTH (DIV_WIDTH)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (active),
    .wide    (s_q.baud_ctrl[BIT_WIDE_DIVIDER]),
    .divisor (s_q.divisor),
    .tick    (tick)
  );

  frame_shifter u_shift (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .active      (active),
    .tick        (tick),
    .load        (load),
    .load_data   ({s_q.held_nine, s_q.holding}),
    .load_nine   (s_q.tx_ctrl[BIT_NINE_SELECT]),
    .shift_empty (shift_empty),
    .stop_begun  (stop_begun),
    .line        (raw_line)
  );

  // ****************************************************************
  // AXI4-Lite handshakes
  // ****************************************************************
  assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
  assign s_axi_wready  = ~s_q.w_got & ~s_q.bvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign wr_fire       = s_q.aw_got & s_q.w_got & ~s_q.bvalid;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    // holding register drains into the shifter
    if (load) begin
      s_d.pending = 1'b0;
    end
    // a disabled path drops any waiting character
    if (!active) begin
      s_d.pending = 1'b0;
    end
    // perform the write once both halves are in
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case ({s_q.aw_addr[7:2], 2'b00})
        ADDR_TX_STATUS_CONTROL: begin
          s_d.tx_ctrl = merge8(s_q.tx_ctrl, s_q.w_data, s_q.w_strb);
          s_d.tx_ctrl[BIT_SHIFT_EMPTY] = 1'b0;
        end
        ADDR_RX_STATUS_CONTROL: s_d.rx_ctrl = merge8(s_q.rx_ctrl, s_q.w_data, s_q.w_strb);
        ADDR_BAUD_CONTROL:      s_d.baud_ctrl = merge8(s_q.baud_ctrl, s_q.w_data, s_q.w_strb);
        ADDR_BAUD_DIVISOR: begin
          if (s_q.w_strb[0]) s_d.divisor[7:0] = s_q.w_data[7:0];
          if (s_q.w_strb[1]) s_d.divisor[DIV_WIDTH-1:8] = s_q.w_data[DIV_WIDTH-1:8];
        end
        ADDR_HOLDING: begin
          // only a write while active and empty is accepted
          if (s_q.w_strb[0] && holding_empty) begin
            s_d.holding   = s_q.w_data[7:0];
            s_d.held_nine = s_q.tx_ctrl[BIT_NINTH_VALUE];
            s_d.pending   = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // read path: status bits are live
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata  = '0;
      case ({s_axi_araddr[7:2], 2'b00})
        ADDR_TX_STATUS_CONTROL: begin
          s_d.rdata[7:0] = s_q.tx_ctrl;
          s_d.rdata[BIT_SHIFT_EMPTY] = shift_empty;
        end
        ADDR_RX_STATUS_CONTROL: s_d.rdata[7:0] = s_q.rx_ctrl;
        ADDR_BAUD_CONTROL:      s_d.rdata[7:0] = s_q.baud_ctrl;
        ADDR_BAUD_DIVISOR:      s_d.rdata[DIV_WIDTH-1:0] = s_q.divisor;
        ADDR_FLAGS:             s_d.rdata[BIT_HOLDING_EMPTY] = holding_empty;
        default: ;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // pin driver and polarity; NRZ passes the bit level straight out
    s_d.out_q = raw_line ^ s_q.baud_ctrl[BIT_INVERT_TX];
    s_d.oe_q  = s_q.rx_ctrl[BIT_PORT_ENABLE];
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign serial_out_pin_o    = s_q.out_q;
  assign serial_out_internal = s_q.out_q;
  assign serial_out_pin_oe   = s_q.oe_q;

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q           <= '0;
      s_q.tx_ctrl   <= RESET_CONTROL;
      s_q.rx_ctrl   <= RESET_CONTROL;
      s_q.baud_ctrl <= RESET_CONTROL;
      s_q.divisor   <= RESET_DIVISOR;
      s_q.out_q     <= LINE_MARK;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // async_serial_transmitter

// File: logic/serial_tx_pkg.sv
// package: register map, field positions, reset values and enumerations of the serial transmitter
package serial_tx_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_TX_STATUS_CONTROL = 8'h00; // transmit_status_control
  localparam logic [7:0] ADDR_RX_STATUS_CONTROL = 8'h04; // receive_status_control
  localparam logic [7:0] ADDR_BAUD_CONTROL      = 8'h08; // baud_control
  localparam logic [7:0] ADDR_BAUD_DIVISOR      = 8'h0c; // divider reload, 16 bits
  localparam logic [7:0] ADDR_HOLDING           = 8'h10; // transmit_holding_register, write only
  localparam logic [7:0] ADDR_FLAGS             = 8'h14; // holding_empty_flag, read only

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_NINTH_VALUE   = 0; // transmit_status_control
  localparam int BIT_SHIFT_EMPTY   = 1;
  localparam int BIT_SYNC_MODE     = 4;
  localparam int BIT_TX_ENABLE     = 5;
  localparam int BIT_NINE_SELECT   = 6;
  localparam int BIT_PORT_ENABLE   = 7; // receive_status_control
  localparam int BIT_INVERT_TX     = 4; // baud_control
  localparam int BIT_WIDE_DIVIDER  = 3;
  localparam int BIT_HOLDING_EMPTY = 0; // flags

  // ****************************************************************
  // reset values and bus answers
  // ****************************************************************
  localparam logic [7:0]  RESET_CONTROL = 8'h00;
  localparam logic [15:0] RESET_DIVISOR = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  localparam logic        LINE_MARK     = 1'b1;
  localparam logic        LINE_SPACE    = 1'b0;
  localparam int          DATA_BITS_MIN = 8;
  localparam int          DATA_BITS_MAX = 9;

  // ****************************************************************
  // transmitter states
  // ****************************************************************
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP
  } tx_state_t;

endpackage

// File: logic/baud_divider.sv
// baud divider: one-cycle bit-period enable from the system clock, 8- or 16-bit counter
`timescale 1ns/1ns
module baud_divider #(
  parameter int WIDTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             run,
  input  wire logic             wide,
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  tick
);
  import serial_tx_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;
  logic [WIDTH-1:0] limit;

  // narrow mode uses only the low byte of the reload value
  always_comb begin
    limit = wide ? divisor : {{(WIDTH-8){1'b0}}, divisor[7:0]};
    s_d   = s_q;
    tick  = 1'b0;
    if (!run) begin
      s_d.count = '0;
    end else if (s_q.count >= limit) begin
      s_d.count = '0;
      tick      = 1'b1;           // period is limit+1 cycles
    end else begin
      s_d.count = s_q.count + 1'b1;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // baud_divider

// File: logic/frame_shifter.sv
// frame shifter: start bit, 8 or 9 data bits LSB first, one stop bit, idle at mark
`timescale 1ns/1ns
module frame_shifter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       active,
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic [8:0] load_data,
  input  wire logic       load_nine,
  output logic            shift_empty,
  output logic            stop_begun,
  output logic            line
);
  import serial_tx_pkg::*;

  typedef struct packed {
    tx_state_t  state;
    logic [8:0] shift;
    logic [3:0] index;
    logic       nine;
    logic       queued;                                  // next character already in shifter
    logic       line;
  } sh_state_t;

  sh_state_t s_q;
  sh_state_t s_d;

  // frame sequencing, one bit per tick
  always_comb begin
    s_d        = s_q;
    stop_begun = 1'b0;
    if (!active) begin
      s_d.state  = TX_IDLE;
      s_d.line   = LINE_MARK;
      s_d.queued = 1'b0;
    end else begin
      case (s_q.state)
        TX_IDLE: begin
          s_d.line   = LINE_MARK;
          s_d.queued = 1'b0;
          if (load) begin
            s_d.shift = load_data;
            s_d.nine  = load_nine;
            s_d.index = '0;
            s_d.state = TX_START;
          end
        end
        TX_START: begin
          if (tick) begin
            s_d.line  = LINE_SPACE;
            s_d.state = TX_DATA;
          end
        end
        TX_DATA: begin
          if (tick) begin
            if (s_q.index == (s_q.nine ? 4'(DATA_BITS_MAX) : 4'(DATA_BITS_MIN))) begin
              s_d.line   = LINE_MARK;
              s_d.state  = TX_STOP;
              stop_begun = 1'b1;
              // data bits are all out, so the pending character can move in now
              if (load) begin
                s_d.shift  = load_data;
                s_d.nine   = load_nine;
                s_d.index  = '0;
                s_d.queued = 1'b1;
              end
            end else begin
              s_d.line  = s_q.shift[0];
              s_d.shift = {1'b0, s_q.shift[8:1]};
              s_d.index = s_q.index + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            if (s_q.queued) begin
              s_d.line   = LINE_SPACE;
              s_d.state  = TX_DATA;
              s_d.queued = 1'b0;
            end else begin
              s_d.state = TX_IDLE;
            end
          end
        end
        default: s_d.state = TX_IDLE;
      endcase
    end
  end

  assign shift_empty = (s_q.state == TX_IDLE);
  assign line        = s_q.line;

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q       <= '0;
      s_q.state <= TX_IDLE;
      s_q.line  <= LINE_MARK;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // frame_shifter

// File: test/async_serial_transmitter_sva.sv
// checker: bus answers and serial line timing of the transmitter
`timescale 1ns/1ns
module async_serial_transmitter_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe,
  input wire logic        serial_out_internal
);
  import serial_tx_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************************************
  // properties
  // ****************************************************************
  // line bits last at least one period of four cycles (divisor 3 or more)
  a_internal_copy: assert property (serial_out_internal == serial_out_pin_o)
    else $error("internal copy differs from pin");
  a_low_bit_len: assert property ($fell(serial_out_pin_o) |=> !serial_out_pin_o [*3])
    else $error("space bit too short");
  a_high_bit_len: assert property ($rose(serial_out_pin_o) |=> serial_out_pin_o [*3])
    else $error("mark bit too short");
  a_idle_mark: assert property (!serial_out_pin_oe [*3] |-> serial_out_pin_o == LINE_MARK)
    else $error("line not at mark while disabled");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_no_take_in_b: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid)
    else $error("read answer timing wrong");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");

  // main scenarios
  c_frame: cover property ($fell(serial_out_pin_o));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_pin_off: cover property ($fell(serial_out_pin_oe));
endmodule // async_serial_transmitter_sva

bind async_serial_transmitter async_serial_transmitter_sva chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .serial_out_pin_o, .serial_out_pin_oe, .serial_out_internal);

// File: test/serial_line_receiver.sv
// partner: remote asynchronous receiver decoding frames on the line
`timescale 1ns/1ns
module serial_line_receiver (
  input wire logic        aclk,
  input wire logic        line,
  input wire logic        nine,
  input wire logic [15:0] bit_len,
  output logic [8:0]      data,
  output logic            bad,
  output logic [15:0]     count,
  output logic [15:0]     gap
);
  logic [15:0] cyc;
  logic [15:0] last;
  int          n;

  // free cycle count for start-to-start spacing
  initial cyc = 16'h0000;
  always @(posedge aclk) cyc <= cyc + 16'h0001;

  // one frame per falling edge, sampled mid-bit
  initial begin
    data = 9'h000;
    bad = 1'b0;
    count = 16'h0000;
    gap = 16'h0000;
    last = 16'h0000;
    forever begin
      @(negedge line);
      gap = cyc - last;
      last = cyc;
      repeat (bit_len / 2) @(posedge aclk);
      if (line !== 1'b0) bad = 1'b1;
      data = 9'h000;
      n = nine ? 9 : 8;
      for (int i = 0; i < n; i++) begin
        repeat (bit_len) @(posedge aclk);
        data[i] = line;
      end
      repeat (bit_len) @(posedge aclk);
      if (line !== 1'b1) bad = 1'b1;
      count = count + 16'h0001;
    end
  end
endmodule // serial_line_receiver

// File: test/async_serial_transmitter_bench.sv
// bench: register access, frame decoding and enable sequencing of the transmitter
`timescale 1ns/1ns
module async_serial_transmitter_bench;
  import serial_tx_pkg::*;
  logic        aclk, aresetn, nine, bad;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        serial_out_pin_o, serial_out_pin_oe, serial_out_internal;
  logic [15:0] bit_len, count, gap;
  logic [8:0]  data;
  int          errors = 0, num_checks = 0, cycles = 0;

  async_serial_transmitter dut (.*);
  serial_line_receiver rx (.aclk(aclk), .line(serial_out_pin_o), .nine(nine), .bit_len(bit_len),
    .data(data), .bad(bad), .count(count), .gap(gap));

  // clock and hang limit
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      test_done;
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(r), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic tr, ta;
    logic [1:0] rr;
    logic [31:0] rdv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rr = s_axi_rresp;
      rdv = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
    check("rresp", 32'(rr), 32'(er));
    check("rdata", rdv, ed);
  endtask

  task automatic wait_frames(input int n);
    while (count < n) @(posedge aclk);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    nine = 1'b0;
    bit_len = 16'h0004;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("pin", 32'(serial_out_pin_o), 32'(LINE_MARK));
    check("oe", 32'(serial_out_pin_oe), 32'h0);
    rd(ADDR_TX_STATUS_CONTROL, 32'h2, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    rd(ADDR_HOLDING, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    $display("test reset done");
    wr(ADDR_BAUD_DIVISOR, 32'h0103, RESP_OKAY);
    wr(ADDR_RX_STATUS_CONTROL, 32'h80, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    check("oe", 32'(serial_out_pin_oe), 32'h1);
    wr(ADDR_TX_STATUS_CONTROL, 32'h30, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    wr(ADDR_TX_STATUS_CONTROL, 32'h20, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h1, RESP_OKAY);
    $display("test enable done");
    wr(ADDR_HOLDING, 32'ha5, RESP_OKAY);
    wr(ADDR_HOLDING, 32'h3c, RESP_OKAY);
    repeat (2) @(posedge aclk);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    rd(ADDR_TX_STATUS_CONTROL, 32'h20, RESP_OKAY);
    wait_frames(1);
    check("char", 32'(data), 32'ha5);
    wait_frames(2);
    check("char", 32'(data), 32'h3c);
    check("gap", 32'(gap), 32'd40);
    check("frame", 32'(bad), 32'h0);
    repeat (4) @(posedge aclk);
    rd(ADDR_TX_STATUS_CONTROL, 32'h22, RESP_OKAY);
    $display("test back to back done");
    nine <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_TX_STATUS_CONTROL, i ? 32'h60 : 32'h61, RESP_OKAY);
      wr(ADDR_HOLDING, i ? 32'hff : 32'h55, RESP_OKAY);
      wait_frames(3 + i);
      check("char9", 32'(data), i ? 32'h0ff : 32'h155);
    end
    $display("test nine bit done");
    nine <= 1'b0;
    bit_len <= 16'd260;
    wr(ADDR_TX_STATUS_CONTROL, 32'h20, RESP_OKAY);
    wr(ADDR_BAUD_CONTROL, 32'h08, RESP_OKAY);
    wr(ADDR_HOLDING, 32'h96, RESP_OKAY);
    wait_frames(5);
    check("wide", 32'(data), 32'h96);
    $display("test wide divider done");
    bit_len <= 16'h0004;
    wr(ADDR_BAUD_CONTROL, 32'h00, RESP_OKAY);
    wr(ADDR_HOLDING, 32'hff, RESP_OKAY);
    wait (serial_out_pin_o === 1'b0);
    wait (serial_out_pin_o === 1'b1);
    @(posedge aclk);
    wr(ADDR_TX_STATUS_CONTROL, 32'h00, RESP_OKAY);
    rd(ADDR_TX_STATUS_CONTROL, 32'h2, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    check("pin", 32'(serial_out_pin_o), 32'(LINE_MARK));
    wr(ADDR_RX_STATUS_CONTROL, 32'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("oe", 32'(serial_out_pin_oe), 32'h0);
    $display("test abort done");
    test_done;
  end
endmodule // async_serial_transmitter_bench
